// [slf_pkg.sv]
/*
 * slf_pkg: register map, field positions, reset values, state types
 * for the synchronous link frame receiver.
 * Assumes a 200 MHz ref_clk and byte-wide registers on a 32-bit bus.
 */
package slf_pkg;
	// ------------------------------------------------------------
	// bus byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_DATA = 8'h04;
	localparam logic [7:0] A_RXBUF = 8'h08;
	localparam logic [7:0] A_TXBUF = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	// ------------------------------------------------------------
	// pointer values and command codes
	// ------------------------------------------------------------
	localparam logic [2:0] P_INTMODE = 3'h1;
	localparam logic [2:0] P_VECTOR = 3'h2;
	localparam logic [2:0] P_RXCTRL = 3'h3;
	localparam logic [2:0] P_TXCTRL = 3'h5;
	localparam logic [2:0] P_STADDR = 3'h6;
	localparam logic [2:0] P_FLAG = 3'h7;
	localparam int CMD_CODE_LSB = 3;
	localparam logic [2:0] C_ABORT = 3'h1;
	localparam logic [2:0] C_INTNEXT = 3'h4;
	localparam logic [2:0] C_ERRRST = 3'h6;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int IM_SAV = 2;
	localparam int IM_RXM = 3;
	localparam int IM_DMA = 5;
	localparam logic [1:0] RXM_OFF = 2'h0;
	localparam logic [1:0] RXM_FIRST = 2'h1;
	localparam logic [1:0] RXM_EVERY = 2'h2;
	localparam int RC_EN = 0;
	localparam int RC_ADDR = 2;
	localparam int RC_CRC = 3;
	localparam int RC_HUNT = 4;
	localparam int RC_SDLC = 7;
	localparam int TC_CRC = 0;
	localparam int TC_EN = 3;
	localparam int SR_EOF = 7;
	localparam int SR_CRC = 6;
	localparam int SR_OVR = 5;
	localparam logic [2:0] VC_IDLE = 3'h0;
	localparam logic [2:0] VC_RXCHAR = 3'h2;
	localparam logic [2:0] VC_SPECIAL = 3'h3;
	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] FLAG_RST = 8'h7E;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_GOOD = 16'h0000;
	localparam logic [4:0] SYNC_CHK_BITS = 5'h10;
	localparam logic [3:0] FLAG_FILL = 4'h8;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		RX_HUNT = 5'h01, RX_SYNC1 = 5'h02, RX_SYNC = 5'h04, RX_FRAME = 5'h08, RX_SKIP = 5'h10
	} slf_rx_t;
	typedef enum logic [4:0] {
		TX_MARK = 5'h01, TX_FLAG = 5'h02, TX_DATA = 5'h04, TX_FCS = 5'h08, TX_ABORT = 5'h10
	} slf_tx_t;
	typedef struct packed {
		logic [1:0] rxcS, rxdS, txcS;
		logic rxcPrev, txcPrev, ack;
		logic [31:0] dat;
		logic [2:0] ptr;
		logic [7:0] intMode, vector, rxCtrl, txCtrl, stAddr, flagPat;
		slf_rx_t rxSt;
		logic [7:0] rxWin, rxSh, rxBuf;
		logic [2:0] rxCnt, ones, oOnes;
		logic [3:0] fill;
		logic gotData, rxFull, overrun, crcErr, eof, open, chk, firstArm, firstPend;
		logic [4:0] dly;
		slf_tx_t txSt;
		logic [7:0] txSh, txBuf;
		logic [3:0] txCnt;
		logic [2:0] txOnes;
		logic txFull, abortReq, txd, irq, dma;
		logic [7:0] vec;
	} slf_state_t;
	localparam slf_state_t ST_RST = '{rxSt: RX_HUNT, txSt: TX_MARK, flagPat: FLAG_RST,
		txd: 1'b1, firstArm: 1'b1, default: '0};
endpackage

// [slf_crc_if.sv]
/*
 * slf_crc_if: control and result of one frame check unit.
 * Assumes both sides run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface slf_crc_if;
	logic init;
	logic en;
	logic din;
	logic [15:0] crc;
	modport ctl(output init, output en, output din, input crc);
	modport unit(input init, input en, input din, output crc);
endinterface
`default_nettype wire

// [slf_crc_unit.sv]
/*
 * slf_crc_unit: bit-serial 16-bit frame check register.
 * Assumes init and en are single ref_clk pulses from the framer.
 */
`timescale 1ns/1ps
`default_nettype none
module slf_crc_unit
	import slf_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// check unit port
	slf_crc_if.unit crcPort
);
	logic [15:0] crc;
	logic [15:0] next_crc;

	always_comb begin
		next_crc = crc;
		if (crcPort.init) begin
			next_crc = CRC_PRESET;
		end else if (crcPort.en) begin
			next_crc = {crc[14:0], 1'b0} ^ ((crcPort.din ^ crc[15]) ? CRC_POLY : 16'h0000);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			crc <= CRC_PRESET;
		end else begin
			crc <= next_crc;
		end
	end

	assign crcPort.crc = crc;

	preset_ones_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		crcPort.init |=> crc == CRC_PRESET) else $error("check preset not all ones");
endmodule
`default_nettype wire

// [slf_frame_top.sv]
/*
 * slf_frame_top: synchronous serial channel, character sync receive and
 * bit-oriented framing, with a classic Wishbone register slave.
 * Assumes rxClk, rxSerial and txClk are asynchronous and far slower than ref_clk.
 */
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - first-char mode interrupts once for first data char; later chars pace DMA.
// - special receive conditions still interrupt while DMA moves data.
// - status-affects-vector acts only on the second channel.
// - hunt declares sync only after two consecutive sync characters.
// - receive errors interrupt the processor so software can retry; a check error in character sync mode sets no interrupt here.
// - bit mode accepts frames of any pattern and length.
// - device sends opening and closing flags and detects them on receive.
// - receiver accepts shared-zero flags; transmitter never emits them.
// - address search compares first 8-bit field with station address.
// - control field passes to processor unaltered as data.
// - frame check generator presets to all ones.
// - receive checker resets on every opening flag.
// - transmitter appends check sequence then closing flag.
// - insert zero after five ones on transmit, delete it on receive.
// - command register selects registers and issues commands; others hold settings.
// - sync modes report check result sixteen bit times after buffer load.
// - zero insertion never applies to flags or aborts.
module slf_frame_top
	import slf_pkg::*;
#(
	parameter bit CHAN_B = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// wishbone slave
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic we_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial line
	input wire logic rxClk,
	input wire logic rxSerial,
	input wire logic txClk,
	output logic txSerial,
	// processor and dma side
	output logic irqOut,
	output logic dmaReq,
	output logic [7:0] vecOut
);
	slf_state_t s;
	slf_state_t next_s;
	slf_crc_if rxCrc();
	slf_crc_if txCrc();
	logic rInit, rEn, rDin, tInit, tEn, tDin;
	logic rxEdge, txFall, rxBit, eBit, isFlag, abrt, busGo, wr, dlv, addrMiss, go, sdlc;
	logic [7:0] win, byteVal, regRd, stat;
	logic [1:0] rxm;
	logic [2:0] cmd;

	slf_crc_unit uRxCrc(.ref_clk(ref_clk), .rstn(rstn), .crcPort(rxCrc));
	slf_crc_unit uTxCrc(.ref_clk(ref_clk), .rstn(rstn), .crcPort(txCrc));
	assign rxCrc.init = rInit;
	assign rxCrc.en = rEn;
	assign rxCrc.din = rDin;
	assign txCrc.init = tInit;
	assign txCrc.en = tEn;
	assign txCrc.din = tDin;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		{rInit, rEn, rDin, tInit, tEn, tDin, dlv, addrMiss} = '0;
		byteVal = '0;
		next_s.rxcS = {s.rxcS[0], rxClk};
		next_s.rxdS = {s.rxdS[0], rxSerial};
		next_s.txcS = {s.txcS[0], txClk};
		next_s.rxcPrev = s.rxcS[1];
		next_s.txcPrev = s.txcS[1];
		rxEdge = s.rxcS[1] & ~s.rxcPrev;
		txFall = ~s.txcS[1] & s.txcPrev;
		rxBit = s.rxdS[1];
		eBit = s.rxWin[0];
		win = {rxBit, s.rxWin[7:1]};
		isFlag = (win == s.flagPat);
		abrt = rxBit & (s.ones >= 3'h6);
		sdlc = s.rxCtrl[RC_SDLC];
		rxm = s.intMode[IM_RXM +: 2];
		go = sdlc & s.txCtrl[TC_EN];
		cmd = dat_i[CMD_CODE_LSB +: 3];
		stat = {s.eof, s.crcErr, s.overrun, 5'h00};
		case (s.ptr)
			3'h0: regRd = {5'h00, s.txFull, s.rxSt == RX_SYNC | s.rxSt == RX_FRAME, s.rxFull};
			P_INTMODE: regRd = stat;
			P_VECTOR: regRd = s.vector;
			P_RXCTRL: regRd = s.rxCtrl;
			P_TXCTRL: regRd = s.txCtrl;
			P_STADDR: regRd = s.stAddr;
			P_FLAG: regRd = s.flagPat;
			default: regRd = 8'h00;
		endcase
		// bus slave, one wait state
		busGo = cyc_i & stb_i & ~s.ack;
		wr = busGo & we_i & sel_i[0];
		next_s.ack = busGo;
		if (busGo & ~we_i) begin
			case (adr_i)
				A_CMD: next_s.dat = {29'h0, s.ptr};
				A_DATA: next_s.dat = {24'h0, regRd};
				A_RXBUF: next_s.dat = {24'h0, s.rxBuf};
				A_STAT: next_s.dat = {24'h0, regRd};
				default: next_s.dat = 32'h0000_0000;
			endcase
			if (adr_i == A_RXBUF) begin
				next_s.rxFull = 1'b0;
				next_s.firstPend = 1'b0;
			end
		end
		if (busGo & adr_i == A_DATA) begin
			next_s.ptr = 3'h0;
		end
		if (wr & adr_i == A_CMD) begin
			next_s.ptr = dat_i[2:0];
			case (cmd)
				C_ABORT: next_s.abortReq = 1'b1;
				C_INTNEXT: next_s.firstArm = 1'b1;
				C_ERRRST: {next_s.overrun, next_s.crcErr, next_s.eof} = 3'h0;
				default: ;
			endcase
		end
		if (wr & adr_i == A_DATA) begin
			case (s.ptr)
				P_INTMODE: next_s.intMode = dat_i[7:0];
				P_VECTOR: next_s.vector = dat_i[7:0];
				P_RXCTRL: next_s.rxCtrl = dat_i[7:0] & ~(8'h01 << RC_HUNT);
				P_TXCTRL: next_s.txCtrl = dat_i[7:0];
				P_STADDR: next_s.stAddr = dat_i[7:0];
				P_FLAG: next_s.flagPat = dat_i[7:0];
				default: ;
			endcase
			if (s.ptr == P_RXCTRL & dat_i[RC_HUNT]) begin
				next_s.rxSt = RX_HUNT;
			end
		end
		if (wr & adr_i == A_TXBUF) begin
			next_s.txBuf = dat_i[7:0];
			next_s.txFull = 1'b1;
		end
		// ------------------------------------------------------------
		// receiver
		// ------------------------------------------------------------
		if (s.open) begin
			rInit = 1'b1;
			next_s.open = 1'b0;
			next_s.chk = 1'b0;
			if (s.chk) begin
				next_s.eof = 1'b1;
				if (rxCrc.crc != CRC_GOOD) begin
					next_s.crcErr = 1'b1;
				end
			end
		end
		if (rxEdge & !sdlc & s.dly != 5'h00) begin
			next_s.dly = s.dly - 5'h01;
			if (s.dly == 5'h01) begin
				next_s.crcErr = (rxCrc.crc != CRC_GOOD);
			end
		end
		if (!s.rxCtrl[RC_EN]) begin
			next_s.rxSt = RX_HUNT;
		end else if (rxEdge) begin
			next_s.rxWin = win;
			next_s.ones = rxBit ? ((s.ones == 3'h7) ? 3'h7 : s.ones + 3'h1) : 3'h0;
			if (sdlc) begin
				if (s.rxSt == RX_FRAME) begin
					if (s.fill != 4'h0) begin
						next_s.fill = s.fill - 4'h1;
					end else if (s.oOnes == STUFF_RUN & !eBit) begin
						next_s.oOnes = 3'h0;
					end else begin
						next_s.oOnes = eBit ? ((s.oOnes == 3'h7) ? 3'h7 : s.oOnes + 3'h1) : 3'h0;
						rEn = 1'b1;
						rDin = eBit;
						next_s.rxSh = {eBit, s.rxSh[7:1]};
						next_s.rxCnt = s.rxCnt + 3'h1;
						if (s.rxCnt == 3'h7) begin
							byteVal = {eBit, s.rxSh[7:1]};
							addrMiss = !s.gotData & s.rxCtrl[RC_ADDR] & byteVal != s.stAddr;
							dlv = !addrMiss;
							next_s.gotData = 1'b1;
							if (addrMiss) begin
								next_s.rxSt = RX_SKIP;
							end
						end
					end
				end
				if (abrt & s.rxSt == RX_FRAME) begin
					next_s.rxSt = RX_HUNT;
				end else if (isFlag & s.rxSt != RX_SYNC1 & s.rxSt != RX_SYNC) begin
					next_s.chk = (s.rxSt == RX_FRAME) & (s.gotData | dlv);
					next_s.open = 1'b1;
					next_s.rxSt = RX_FRAME;
					next_s.fill = FLAG_FILL;
					next_s.rxCnt = 3'h0;
					next_s.oOnes = 3'h0;
					next_s.gotData = 1'b0;
				end else if (s.rxSt == RX_SYNC1 | s.rxSt == RX_SYNC) begin
					next_s.rxSt = RX_HUNT;
				end
			end else begin
				case (s.rxSt)
					RX_HUNT: begin
						if (win == s.stAddr) begin
							next_s.rxSt = RX_SYNC1;
							next_s.rxCnt = 3'h0;
						end
					end
					RX_SYNC1: begin
						next_s.rxCnt = s.rxCnt + 3'h1;
						if (s.rxCnt == 3'h7) begin
							next_s.rxSt = (win == s.flagPat) ? RX_SYNC : RX_HUNT;
							next_s.gotData = 1'b0;
						end
					end
					RX_SYNC: begin
						next_s.rxSh = win;
						next_s.rxCnt = s.rxCnt + 3'h1;
						rEn = s.rxCtrl[RC_CRC];
						rDin = rxBit;
						if (s.rxCnt == 3'h7) begin
							byteVal = win;
							dlv = s.gotData | (win != s.stAddr & win != s.flagPat);
							next_s.gotData = s.gotData | dlv;
							if (dlv) begin
								next_s.dly = SYNC_CHK_BITS;
							end
						end
					end
					default: next_s.rxSt = RX_HUNT;
				endcase
			end
		end
		if (dlv) begin
			if (next_s.rxFull) begin
				next_s.overrun = 1'b1;
			end
			next_s.rxBuf = byteVal;
			next_s.rxFull = 1'b1;
			if (rxm == RXM_FIRST & s.firstArm) begin
				next_s.firstPend = 1'b1;
				next_s.firstArm = 1'b0;
			end
		end
		// ------------------------------------------------------------
		// transmitter
		// ------------------------------------------------------------
		if (!go) begin
			next_s.txSt = TX_MARK;
			next_s.txd = 1'b1;
		end else if (txFall) begin
			next_s.txCnt = s.txCnt + 4'h1;
			case (s.txSt)
				TX_MARK: begin
					next_s.txSt = TX_FLAG;
					next_s.txSh = s.flagPat;
					next_s.txCnt = 4'h0;
				end
				TX_FLAG, TX_ABORT: begin
					next_s.txd = (s.txSt == TX_ABORT) | s.txSh[0];
					next_s.txSh = {1'b0, s.txSh[7:1]};
					if (s.txCnt == ((s.txSt == TX_ABORT) ? 4'h6 : 4'h7)) begin
						next_s.txCnt = 4'h0;
						next_s.txOnes = 3'h0;
						next_s.txSh = s.flagPat;
						next_s.txSt = TX_FLAG;
						if (s.txFull & s.txSt == TX_FLAG) begin
							tInit = 1'b1;
							next_s.txSt = TX_DATA;
							next_s.txSh = s.txBuf;
							next_s.txFull = 1'b0;
						end
					end
				end
				TX_DATA, TX_FCS: begin
					if (s.txOnes == STUFF_RUN) begin
						next_s.txd = 1'b0;
						next_s.txOnes = 3'h0;
						next_s.txCnt = s.txCnt;
					end else begin
						next_s.txd = (s.txSt == TX_DATA) ? s.txSh[0] : txCrc.crc[15];
						tEn = 1'b1;
						tDin = next_s.txd;
						next_s.txOnes = next_s.txd ? s.txOnes + 3'h1 : 3'h0;
						next_s.txSh = {1'b0, s.txSh[7:1]};
						if (s.txSt == TX_DATA & s.txCnt == 4'h7) begin
							next_s.txCnt = 4'h0;
							if (s.txFull) begin
								next_s.txSh = s.txBuf;
								next_s.txFull = 1'b0;
							end else begin
								next_s.txSt = s.txCtrl[TC_CRC] ? TX_FCS : TX_FLAG;
								next_s.txSh = s.flagPat;
							end
						end else if (s.txSt == TX_FCS & s.txCnt == 4'hF) begin
							next_s.txCnt = 4'h0;
							next_s.txSt = TX_FLAG;
							next_s.txSh = s.flagPat;
						end
					end
				end
				default: next_s.txSt = TX_MARK;
			endcase
			if (s.abortReq & s.txSt != TX_MARK & s.txSt != TX_ABORT &
				(s.txSt != TX_FLAG | s.txCnt == 4'h0)) begin
				next_s.txSt = TX_ABORT;
				next_s.txd = 1'b1;
				next_s.txCnt = 4'h0;
				next_s.txFull = 1'b0;
				next_s.abortReq = 1'b0;
			end
		end
		// ------------------------------------------------------------
		// processor and dma pacing
		// ------------------------------------------------------------
		// special conditions interrupt
		next_s.irq = (next_s.intMode[IM_RXM +: 2] != RXM_OFF) & (next_s.firstPend |
			next_s.overrun | next_s.eof |
			(next_s.intMode[IM_RXM +: 2] == RXM_EVERY & next_s.rxFull));
		next_s.dma = next_s.intMode[IM_DMA] & next_s.rxFull & ~next_s.firstPend;
		next_s.vec = next_s.vector;
		if (CHAN_B & next_s.intMode[IM_SAV]) begin
			next_s.vec[3:1] = (next_s.overrun | next_s.eof) ? VC_SPECIAL :
				(next_s.rxFull ? VC_RXCHAR : VC_IDLE);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s <= ST_RST;
		end else begin
			s <= next_s;
		end
	end

	assign dat_o = s.dat;
	assign ack_o = s.ack;
	assign txSerial = s.txd;
	assign irqOut = s.irq;
	assign dmaReq = s.dma;
	assign vecOut = s.vec;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence flagOpenS;
		rxEdge && sdlc && s.rxCtrl[RC_EN] && isFlag && !abrt;
	endsequence
	sequence presetS;
		rxCrc.init ##1 (rxCrc.crc == CRC_PRESET);
	endsequence
	ack_pulse_a: assert property (s.ack |=> !s.ack)
		else $error("ack held longer than one cycle");
	ack_time_a: assert property (busGo |=> s.ack)
		else $error("ack not one cycle after request");
	first_int_a: assert property (dlv && rxm == RXM_FIRST && s.firstArm
		|=> s.firstPend && !s.firstArm) else $error("first char did not interrupt");
	first_once_a: assert property (!s.firstArm |=> !$rose(s.firstPend))
		else $error("second char raised first-char interrupt");
	special_irq_a: assert property (s.eof && rxm != RXM_OFF |-> s.irq)
		else $error("frame end did not interrupt");
	error_irq_a: assert property (s.overrun && rxm != RXM_OFF |-> s.irq)
		else $error("overrun did not interrupt");
	vec_chan_a: assert property (!CHAN_B || !s.intMode[IM_SAV] |-> s.vec == s.vector)
		else $error("vector modified without status option");
	hunt_two_a: assert property (s.rxSt == RX_HUNT |=> s.rxSt != RX_SYNC)
		else $error("sync declared on one character");
	open_crc_a: assert property (flagOpenS |=> presetS)
		else $error("checker not reset on opening flag");
	addr_skip_a: assert property (addrMiss |=> s.rxSt == RX_SKIP && !s.rxFull)
		else $error("foreign frame not discarded");
	tx_stuff_a: assert property (go && txFall && !s.abortReq && s.txOnes == STUFF_RUN &&
		(s.txSt == TX_DATA || s.txSt == TX_FCS) |=> !s.txd) else $error("zero not inserted");
	tx_fcs_a: assert property (go && txFall && !s.abortReq && s.txSt == TX_DATA &&
		s.txCnt == 4'h7 && s.txOnes != STUFF_RUN && !s.txFull && s.txCtrl[TC_CRC]
		|=> s.txSt == TX_FCS) else $error("check sequence not appended");
	tx_open_a: assert property ($rose(s.txSt == TX_DATA) |-> $past(s.txSt) == TX_FLAG)
		else $error("frame started without flag");
	sync_delay_a: assert property (rxEdge && !sdlc && s.dly == 5'h01
		|=> s.crcErr == ($past(rxCrc.crc) != CRC_GOOD)) else $error("delayed result wrong");
endmodule
`default_nettype wire

// [slf_station.sv]
/*
 * slf_station: remote station on the serial line; sends character and
 * bit-oriented frames, watches the transmit line.
 * Assumes the bench calls its tasks and reads maxOnes and flagSeen.
 */
`timescale 1ns/1ps
`default_nettype none
module slf_station
	import slf_pkg::*;
(
	// receive side of the block
	output logic rxClk,
	output logic rxSerial,
	// transmit side of the block
	output logic txClk,
	input wire logic txSerial
);
	// ------------------------------------------------------------
	// line model
	// ------------------------------------------------------------
	logic [15:0] crc;
	logic [2:0] run;
	logic [7:0] txHist;
	logic [3:0] txOnes;
	logic [3:0] maxOnes;
	logic flagSeen;
	initial begin
		rxClk = 1'b0;
		rxSerial = 1'b1;
		txClk = 1'b0;
		txHist = 8'h00;
		txOnes = 4'h0;
		maxOnes = 4'h0;
		flagSeen = 1'b0;
	end
	always #24 txClk = ~txClk;
	// longest run of ones and flags seen on transmit
	always @(posedge txClk) begin
		txHist = {txSerial, txHist[7:1]};
		txOnes = txSerial ? ((txOnes == 4'hF) ? txOnes : txOnes + 4'h1) : 4'h0;
		if (txOnes > maxOnes) maxOnes = txOnes;
		if (txHist == FLAG_RST) flagSeen = 1'b1;
	end
	// data set up while clock low, taken at its rise
	task automatic putBit(input logic b);
		rxSerial = b;
		#24 rxClk = 1'b1;
		#24 rxClk = 1'b0;
	endtask
	task automatic sendChars(input logic [7:0] q[$]);
		foreach (q[i]) for (int k = 0; k < 8; k++) putBit(q[i][k]);
		rxSerial = ~rxSerial;
	endtask
	task automatic putData(input logic b);
		crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
		putBit(b);
		run = b ? run + 3'h1 : 3'h0;
		if (run == STUFF_RUN) begin
			putBit(1'b0);
			run = 3'h0;
		end
	endtask
	// shared-zero opening, check bits, closing flags
	task automatic sendFrame(input logic [7:0] q[$], input logic bad);
		logic [15:0] fcs;
		for (int k = 0; k < 7; k++) putBit(FLAG_RST[k]);
		for (int k = 0; k < 8; k++) putBit(FLAG_RST[k]);
		crc = CRC_PRESET;
		run = 3'h0;
		foreach (q[i]) for (int k = 0; k < 8; k++) putData(q[i][k]);
		fcs = crc ^ {15'h0000, bad};
		for (int k = 15; k >= 0; k--) putData(fcs[k]);
		for (int k = 0; k < 24; k++) putBit(FLAG_RST[k % 8]);
		rxSerial = ~rxSerial;
	endtask
endmodule
`default_nettype wire

// [sync_link_frame_receiver_bench.sv]
/*
 * sync_link_frame_receiver_bench: self-checking bench for slf_frame_top.
 * Assumes slf_station stands at the far end of the serial line.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_link_frame_receiver_bench
	import slf_pkg::*;
;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] datI = 32'h00000000;
	logic [3:0] sel = 4'hF;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ack, rxClk, rxSerial, txClk, txSerial, irq, dma;
	logic [7:0] vec;
	logic [31:0] datO, rd;
	int badCount = 0;
	int nCompared = 0;
	int cycles = 0;
	slf_frame_top #(.CHAN_B(1'b1)) dut (.ref_clk(ref_clk), .rstn(rstn), .adr_i(adr),
		.dat_i(datI), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(datO),
		.ack_o(ack), .rxClk(rxClk), .rxSerial(rxSerial), .txClk(txClk),
		.txSerial(txSerial), .irqOut(irq), .dmaReq(dma), .vecOut(vec));
	slf_station stn (.rxClk(rxClk), .rxSerial(rxSerial), .txClk(txClk), .txSerial(txSerial));
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			badCount++;
			endSim();
		end
	end
	// ------------------------------------------------------------
	// common tasks
	// ------------------------------------------------------------
	task automatic endSim();
		$display("compared %0d, mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		adr <= a;
		we <= w;
		datI <= {24'h000000, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1);
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		check(n, 2);
	endtask
	task automatic setReg(input logic [2:0] p, input logic [7:0] v);
		wb(A_CMD, 1'b1, {5'h00, p});
		wb(A_DATA, 1'b1, v);
	endtask
	task automatic getReg(input logic [2:0] p);
		wb(A_CMD, 1'b1, {5'h00, p});
		wb(A_DATA, 1'b0, 8'h00);
	endtask
	task automatic command(input logic [2:0] c);
		wb(A_CMD, 1'b1, {2'b00, c, 3'b000});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic regScn();
		getReg(P_FLAG);
		check(rd, {24'h000000, FLAG_RST});
		setReg(P_STADDR, 8'h5A);
		getReg(P_STADDR);
		check(rd, 32'h0000005A);
		wb(8'h14, 1'b0, 8'h00);
		check(rd, 32'h00000000);
	endtask
	task automatic charScn();
		setReg(P_STADDR, 8'h32);
		setReg(P_FLAG, 8'h16);
		setReg(P_INTMODE, 8'h0C);
		setReg(P_RXCTRL, 8'h11);
		stn.sendChars({8'h32, 8'h16, 8'h41});
		repeat (10) @(posedge ref_clk);
		check({irq, dma}, 2'b10);
		check(vec[3:1], VC_RXCHAR);
		wb(A_RXBUF, 1'b0, 8'h00);
		check(rd, 32'h00000041);
		setReg(P_INTMODE, 8'h2C);
		setReg(P_RXCTRL, 8'h09);
		stn.sendChars({8'h42});
		repeat (10) @(posedge ref_clk);
		check({irq, dma}, 2'b01);
		wb(A_RXBUF, 1'b0, 8'h00);
		check(rd, 32'h00000042);
		repeat (3) @(posedge ref_clk);
		check({irq, dma}, 2'b00);
		stn.sendChars({8'h43, 8'h44});
		repeat (10) @(posedge ref_clk);
		check({irq, vec[3:1]}, {1'b1, VC_SPECIAL});
		getReg(P_INTMODE);
		check(rd[SR_OVR], 1'b1);
		command(C_ERRRST);
		wb(A_RXBUF, 1'b0, 8'h00);
		repeat (3) @(posedge ref_clk);
		check({irq, dma}, 2'b00);
		command(C_INTNEXT);
		stn.sendChars({8'h45});
		repeat (10) @(posedge ref_clk);
		check({irq, dma}, 2'b10);
	endtask
	// frame on the line while the bus drains the receive buffer
	task automatic frame(input logic [7:0] q[$], input logic bad, input logic [2:0] st,
		input int n);
		logic done;
		int k;
		done = 1'b0;
		k = 0;
		fork
			begin
				stn.sendFrame(q, bad);
				done = 1'b1;
			end
			while (!done) begin
				wb(A_STAT, 1'b0, 8'h00);
				if (rd[0]) begin
					wb(A_RXBUF, 1'b0, 8'h00);
					if (k < q.size()) check(rd, {24'h000000, q[k]});
					k++;
				end
			end
		join
		check(k, n);
		getReg(P_INTMODE);
		check(rd[7:5], st);
		check(rd[SR_CRC], bad);
		command(C_ERRRST);
	endtask
	task automatic bitScn();
		wb(A_RXBUF, 1'b0, 8'h00);
		setReg(P_INTMODE, 8'h00);
		setReg(P_FLAG, FLAG_RST);
		setReg(P_STADDR, 8'h5A);
		setReg(P_RXCTRL, 8'h99);
		frame({8'hA5, 8'hFF, 8'h7E, 8'h3F}, 1'b0, 3'b100, 6);
		frame({8'h81, 8'h00}, 1'b1, 3'b110, 4);
		setReg(P_RXCTRL, 8'h9D);
		frame({8'hA5, 8'h03}, 1'b0, 3'b000, 0);
		frame({8'h5A, 8'h03}, 1'b0, 3'b100, 4);
	endtask
	task automatic txScn();
		setReg(P_TXCTRL, 8'h09);
		repeat (100) @(posedge ref_clk);
		stn.maxOnes = 4'h0;
		repeat (300) @(posedge ref_clk);
		check({stn.flagSeen, stn.maxOnes}, {1'b1, 4'h6});
		repeat (2) begin
			rd = 32'h00000004;
			for (int i = 0; i < 200 && rd[2]; i++) wb(A_STAT, 1'b0, 8'h00);
			wb(A_TXBUF, 1'b1, 8'hFF);
		end
		repeat (600) @(posedge ref_clk);
		check(stn.maxOnes, 4'h6);
		command(C_ABORT);
		repeat (300) @(posedge ref_clk);
		check(stn.maxOnes >= 4'h8 && stn.maxOnes <= 4'hD, 1'b1);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		check({ack, txSerial, irq, dma, vec}, 12'h400);
		regScn();
		charScn();
		bitScn();
		txScn();
		endSim();
	end
endmodule
`default_nettype wire
